// file: psram_defs.vh
// Purpose: shared constants of the x16 ddr pseudo-static dram slave port
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only, no logic
`ifndef PSRAM_DEFS_VH
`define PSRAM_DEFS_VH

// command/address phase: three link cycles, six bytes on dq[7:0]
`define CA_EDGES        3'd6
`define CA_BITS         48
`define CA_RW_BIT       47
`define CA_LINEAR_BIT   45
`define CA_ROW_HI       44
`define CA_ROW_LO       16
`define CA_COL_HI       2
`define CA_COL_LO       0

// data word: two 16-bit halves per link cycle, first half is the upper
`define HALF_W          16
`define WORD_W          32
`define BYTE_W          8

// transaction states
`define ST_IDLE         3'd0
`define ST_CA           3'd1
`define ST_LAT          3'd2
`define ST_RD           3'd3
`define ST_WR           3'd4

// counter widths and reset values
`define LAT_W           8
`define LAT_ZERO        8'h00
`define ADDR_ZERO       32'h00000000
`define ONE32           32'h00000001

`endif

// file: pin_sync.v
// Purpose: three-stage synchroniser for pins from outside the clk domain
// Assumes: one clock; din changes asynchronously to clk
// Notes:   a bit changes only once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
	parameter W = 1
) (
	input  wire         clk,  // system clock
	input  wire         rst,  // async reset, active high
	input  wire [W-1:0] din,  // raw pin levels
	output reg  [W-1:0] dout  // filtered, synchronised levels
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;

	// first stage only feeds the second; output takes agreed bits only
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s1   <= {W{1'b0}};
			s2   <= {W{1'b0}};
			s3   <= {W{1'b0}};
			dout <= {W{1'b0}};
		end else begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			dout <= (s3 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
		end
	end
endmodule

// file: word_fifo.v
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: one clock; flush empties it in one cycle
// Notes:   full and empty come from an occupancy count
`timescale 1ns/100ps
module word_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,       // system clock
	input  wire             rst,       // async reset, active high
	input  wire             flush,     // drop all entries
	input  wire             in_valid,  // producer offers a word
	output wire             in_ready,  // room for a word
	input  wire [WIDTH-1:0] in_data,   // word offered
	output wire             out_valid, // a word is waiting
	input  wire             out_ready, // consumer takes the word
	output wire [WIDTH-1:0] out_data   // oldest word
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = store[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// data storage, no reset needed
	always @(posedge clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	// pointers and occupancy; wrap at depth
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// file: psram_ddr_port.v
// Purpose: slave transaction logic of a x16 ddr self-refreshing dram
// Assumes: link clock is sampled by clk and is much slower; not free-running
// Notes:   array is a small word memory; configuration registers left out
//
// Summary of operation
// - refresh runs internally; it starts only while no transaction is active
// - chip select low, six command bytes, latency, then data until release
// - device drives the strobe during the command phase of every access
// - strobe high in command phase means latency is doubled
// - read data edge-aligned with a strobe toggling each half word
// - write mask high keeps memory, low stores the byte
// - each command picks wrapped or linear; one word per link cycle
// - wrapped burst runs to group end, then wraps toward the start
// - linear burst advances until chip select returns high
// - row and burst type from first two cycles, word from the third
// - linear reads prefetch ahead so row crossings do not stall
// - sixteen bits per edge, two per cycle, double-word addressing
// - mask bit 0 gates dq[7:0], mask bit 1 gates dq[15:8]
// - hardware reset low returns to standby with pins released
`timescale 1ns/100ps
`include "psram_defs.vh"
module psram_ddr_port #(
	parameter LATENCY    = 6,    // link cycles of initial access latency
	parameter MEM_AW     = 8,    // double words in the array, log2
	parameter WRAP_WORDS = 8,    // double words in a wrap group (power of 2)
	parameter REF_PERIOD = 6000, // clk cycles between refresh requests
	parameter REF_BUSY   = 16,   // clk cycles one refresh occupies the array
	parameter FIFO_DEPTH = 8,    // read prefetch depth
	parameter FIFO_AW    = 3     // log2 of the prefetch depth
) (
	input  wire        clk,               // system clock, 200 MHz
	input  wire        rst,               // async reset, active high
	input  wire        reset_n,           // hardware reset pin, active low
	input  wire        cs_n,              // chip select pin, active low
	input  wire        link_ck,           // host link clock pin
	input  wire [15:0] dq_in,             // data pins, input side
	output reg  [15:0] dq_out,            // data pins, output side
	output reg         dq_oe,             // data pins driven
	input  wire [1:0]  byte_strobe_pair_in,  // strobe/mask pins, input
	output reg  [1:0]  byte_strobe_pair_out, // strobe pins, output side
	output reg         byte_strobe_pair_oe   // strobe pins driven
);
	// synchronised pins
	wire [20:0] sync_out;
	wire        s_cs_n;
	wire        s_ck;
	wire [15:0] s_dq;
	wire [1:0]  s_mask;
	wire        s_reset_n;

	pin_sync #(.W(21)) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  ({reset_n, cs_n, link_ck, byte_strobe_pair_in, dq_in}),
		.dout (sync_out)
	);
	assign s_reset_n = sync_out[20];
	assign s_cs_n    = sync_out[19];
	assign s_ck      = sync_out[18];
	assign s_mask    = sync_out[17:16];
	assign s_dq      = sync_out[15:0];

	// transaction state
	reg [2:0]          state;
	reg                ck_prev;
	reg                cs_prev;
	reg [2:0]          ca_cnt;
	reg [`CA_BITS-1:0] ca;
	reg [`LAT_W-1:0]   lat_cnt;
	reg                extra;
	reg                is_read;
	reg                linear;
	reg [31:0]         base;
	reg [31:0]         wr_addr;
	reg [31:0]         rd_addr;
	reg [`HALF_W-1:0]  wr_hi;
	reg [1:0]          wr_mhi;
	reg [`HALF_W-1:0]  rd_lo;
	reg                pf_on;
	reg [`WORD_W-1:0]  mem [0:(1<<MEM_AW)-1];

	// refresh state
	reg [31:0] ref_timer;
	reg        ref_pending;
	reg [15:0] ref_cnt;
	reg        ref_busy;

	// edges of the sampled link clock and chip select, and the reset pin level
	wire rise     = s_ck & ~ck_prev;
	wire fall     = ~s_ck & ck_prev;
	wire cs_start = ~s_cs_n & cs_prev;
	wire hw_reset = ~s_reset_n;

	// latency target: doubled when refresh was flagged
	wire [`LAT_W-1:0] lat_single = LATENCY[`LAT_W-1:0];
	wire [`LAT_W-1:0] lat_target = extra ? {lat_single[`LAT_W-2:0], 1'b0}
		: lat_single;
	wire lat_done = (state == `ST_LAT) & rise &
		(lat_cnt == lat_target - 1'b1);

	// next address in wrapped or linear order
	function [31:0] next_addr;
		input [31:0] a;
		input        lin;
		reg   [31:0] grp;
		begin
			grp = WRAP_WORDS[31:0] - `ONE32;
			if (lin) begin
				next_addr = a + `ONE32;
			end else begin
				next_addr = (a & ~grp) | ((a + `ONE32) & grp);
			end
		end
	endfunction

	// prefetch fifo between array and read pins
	wire              fifo_in_valid;
	wire              fifo_in_ready;
	wire              fifo_out_valid;
	wire [`WORD_W-1:0] fifo_out_data;
	wire              rd_edge = is_read & rise &
		((state == `ST_RD) | lat_done);
	wire              fifo_flush = s_cs_n | hw_reset;

	// array read stalls behind refresh and a full fifo
	assign fifo_in_valid = pf_on & ~ref_busy & ~s_cs_n;

	word_fifo #(
		.WIDTH (`WORD_W),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.flush     (fifo_flush),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (mem[rd_addr[MEM_AW-1:0]]),
		.out_valid (fifo_out_valid),
		.out_ready (rd_edge),
		.out_data  (fifo_out_data)
	);

	// refresh scheduler: a request waits for an idle bus
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_timer   <= `ADDR_ZERO;
			ref_pending <= 1'b0;
			ref_cnt     <= 16'h0000;
			ref_busy    <= 1'b0;
		end else begin
			if (ref_timer == REF_PERIOD - 1) begin
				ref_timer <= `ADDR_ZERO;
			end else begin
				ref_timer <= ref_timer + `ONE32;
			end
			if (ref_busy) begin
				if (ref_cnt == REF_BUSY[15:0] - 16'h0001) begin
					ref_busy <= 1'b0;
				end
				ref_cnt <= ref_cnt + 16'h0001;
			end else if (ref_pending & (state == `ST_IDLE) & s_cs_n) begin
				ref_busy <= 1'b1;
				ref_cnt  <= 16'h0000;
			end
			// a new request in the clearing cycle wins
			if (ref_timer == REF_PERIOD - 1) begin
				ref_pending <= 1'b1;
			end else if (~ref_busy & ref_pending & (state == `ST_IDLE)
				& s_cs_n) begin
				ref_pending <= 1'b0;
			end
		end
	end

	// array writes: one double word per fall, a set mask bit keeps the byte
	wire [`WORD_W-1:0] wr_in   = {wr_hi, s_dq};
	wire [3:0]         wr_keep = {wr_mhi, s_mask};
	wire [`WORD_W-1:0] wr_old  = mem[wr_addr[MEM_AW-1:0]];
	wire [`WORD_W-1:0] wr_word;
	wire               wr_commit = (state == `ST_WR) & fall & ~fifo_flush;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_lane
			assign wr_word[g*`BYTE_W +: `BYTE_W] = wr_keep[g] ?
				wr_old[g*`BYTE_W +: `BYTE_W] : wr_in[g*`BYTE_W +: `BYTE_W];
		end
	endgenerate
	always @(posedge clk) begin
		if (wr_commit) begin
			mem[wr_addr[MEM_AW-1:0]] <= wr_word;
		end
	end

	// edge history
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ck_prev <= 1'b0;
			cs_prev <= 1'b1;
		end else begin
			ck_prev <= s_ck;
			cs_prev <= s_cs_n;
		end
	end

	// transaction sequencer
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state   <= `ST_IDLE;
			ca_cnt  <= 3'd0;
			ca      <= {`CA_BITS{1'b0}};
			lat_cnt <= `LAT_ZERO;
			extra   <= 1'b0;
			is_read <= 1'b0;
			linear  <= 1'b0;
			base    <= `ADDR_ZERO;
			wr_addr <= `ADDR_ZERO;
			rd_addr <= `ADDR_ZERO;
			wr_hi   <= 16'h0000;
			wr_mhi  <= 2'h3;
			pf_on   <= 1'b0;
		end else if (hw_reset | s_cs_n) begin
			state <= `ST_IDLE;
			pf_on <= 1'b0;
		end else begin
			case (state)
				`ST_IDLE: begin
					if (cs_start) begin
						state  <= `ST_CA;
						ca_cnt <= 3'd0;
						extra  <= ref_pending | ref_busy;
					end
				end
				`ST_CA: begin
					// command bytes on dq[7:0], both edges
					if (rise | fall) begin
						ca     <= {ca[`CA_BITS-9:0], s_dq[7:0]};
						ca_cnt <= ca_cnt + 3'd1;
						if (ca_cnt == `CA_EDGES - 3'd1) begin
							state   <= `ST_LAT;
							lat_cnt <= `LAT_ZERO;
						end
					end
				end
				`ST_LAT: begin
					if (lat_cnt == `LAT_ZERO) begin
						// decode on each clk after the sixth byte until the first latency rise
						is_read <= ca[`CA_RW_BIT];
						linear  <= ca[`CA_LINEAR_BIT];
						base    <= {ca[`CA_ROW_HI:`CA_ROW_LO],
							ca[`CA_COL_HI:`CA_COL_LO]};
					end
					if (rise) begin
						lat_cnt <= lat_cnt + 1'b1;
						if (lat_cnt == `LAT_ZERO) begin
							rd_addr <= base;
							wr_addr <= base;
							pf_on   <= is_read;
						end
					end
					if (lat_done) begin
						state  <= is_read ? `ST_RD : `ST_WR;
						wr_hi  <= s_dq; // first upper half rides this rise
						wr_mhi <= s_mask;
					end
				end
				`ST_WR: begin
					// first half on rise, second half commits on fall
					if (rise) begin
						wr_hi  <= s_dq;
						wr_mhi <= s_mask;
					end
					if (fall) begin
						wr_addr <= next_addr(wr_addr, linear);
					end
				end
				`ST_RD: begin
				end
				default: begin
					state <= `ST_IDLE;
				end
			endcase
			// prefetcher walks the burst order ahead of the pins
			if (pf_on & fifo_in_valid & fifo_in_ready) begin
				rd_addr <= next_addr(rd_addr, linear);
			end
		end
	end

	// pin drivers: strobe in command phase, data and strobe on reads
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_out               <= 16'h0000;
			dq_oe                <= 1'b0;
			byte_strobe_pair_out <= 2'h0;
			byte_strobe_pair_oe  <= 1'b0;
			rd_lo                <= 16'h0000;
		end else if (hw_reset | s_cs_n) begin
			dq_oe               <= 1'b0;
			byte_strobe_pair_oe <= 1'b0;
			byte_strobe_pair_out <= 2'h0;
		end else if ((state == `ST_IDLE) | (state == `ST_CA)) begin
			byte_strobe_pair_oe  <= 1'b1;
			byte_strobe_pair_out <= {2{(state == `ST_CA) ? extra :
				(ref_pending | ref_busy)}};
			dq_oe <= 1'b0;
		end else if (state == `ST_LAT) begin
			// reads hold the strobe low once the first latency rise is counted; writes hand it to the host
			byte_strobe_pair_oe  <= is_read & (lat_cnt != `LAT_ZERO);
			byte_strobe_pair_out <= 2'h0;
			if (rd_edge) begin
				dq_oe                <= 1'b1;
				dq_out               <= fifo_out_data[31:16];
				rd_lo                <= fifo_out_data[15:0];
				byte_strobe_pair_oe  <= 1'b1;
				byte_strobe_pair_out <= 2'h3;
			end
		end else if (state == `ST_RD) begin
			// strobe follows each half word edge-aligned
			if (rd_edge) begin
				dq_out               <= fifo_out_data[31:16];
				rd_lo                <= fifo_out_data[15:0];
				byte_strobe_pair_out <= 2'h3;
			end else if (fall) begin
				dq_out               <= rd_lo;
				byte_strobe_pair_out <= 2'h0;
			end
		end else begin
			dq_oe               <= 1'b0;
			byte_strobe_pair_oe <= 1'b0;
		end
	end
endmodule

// file: psram_port_checker_assertions.sv
// Purpose: port-level checks of the ddr dram slave port
// Assumes: bench link clock of 160 ns, that is 32 clk per link cycle
// Notes:   bound to every psram_ddr_port instance
`timescale 1ns/100ps
module psram_port_checker #(
	parameter LATENCY = 6
) (
	input wire        clk,                  // system clock
	input wire        rst,                  // async reset
	input wire        reset_n,              // hardware reset pin
	input wire        cs_n,                 // chip select pin
	input wire        link_ck,              // link clock pin
	input wire [15:0] dq_in,                // data pins in
	input wire [15:0] dq_out,               // data pins out
	input wire        dq_oe,                // data pins driven
	input wire [1:0]  byte_strobe_pair_in,  // strobe pins in
	input wire [1:0]  byte_strobe_pair_out, // strobe pins out
	input wire        byte_strobe_pair_oe   // strobe pins driven
);
	localparam int LO  = (2 + LATENCY) * 32;     // earliest first data
	localparam int HI  = (3 + LATENCY) * 32;     // latest, no refresh
	localparam int LO2 = (2 + 2 * LATENCY) * 32; // earliest with refresh
	logic [15:0] cnt;
	logic        cmd_flag;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// clk cycles since select, and strobe level shown in the command phase
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt      <= 16'h0;
			cmd_flag <= 1'b0;
		end else begin
			cnt <= cs_n ? 16'h0 : (cnt == 16'hffff ? cnt : cnt + 16'h1);
			if (!cs_n && cnt == 16'h0018)
				cmd_flag <= byte_strobe_pair_out[0];
		end
	end
	a_release_idle: assert property (cs_n [*8] |-> !dq_oe)
		else $error("data pins driven while deselected");
	a_reset_pins: assert property ((!reset_n) [*8] |->
		!dq_oe && !byte_strobe_pair_oe) else $error("pins held in reset");
	a_cmd_strobe: assert property ($fell(cs_n) |->
		##[2:12] byte_strobe_pair_oe) else $error("no strobe in command");
	a_strobe_pair: assert property (byte_strobe_pair_oe |->
		byte_strobe_pair_out[1] == byte_strobe_pair_out[0])
		else $error("strobe bits differ");
	a_read_upper: assert property ((dq_oe && link_ck) [*8] |->
		byte_strobe_pair_oe && byte_strobe_pair_out == 2'b11)
		else $error("strobe not high with upper half");
	a_read_lower: assert property ((dq_oe && !link_ck) [*8] |->
		byte_strobe_pair_out == 2'b00) else $error("strobe not low");
	a_data_strobe: assert property (dq_oe |-> byte_strobe_pair_oe)
		else $error("read data without strobe");
	a_single_latency: assert property ($rose(dq_oe) |->
		cnt >= LO && (cmd_flag || cnt <= HI)) else $error("latency off");
	a_refresh_latency: assert property ($rose(dq_oe) && cmd_flag |->
		cnt >= LO2) else $error("refresh latency not added");
	c_refresh: cover property ($rose(dq_oe) && cmd_flag);
	c_plain: cover property ($rose(dq_oe) && !cmd_flag);
	c_abort: cover property ($fell(reset_n) && !cs_n);
endmodule

bind psram_ddr_port psram_port_checker #(.LATENCY(LATENCY)) chk (
	.clk(clk), .rst(rst), .reset_n(reset_n), .cs_n(cs_n),
	.link_ck(link_ck), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
	.byte_strobe_pair_in(byte_strobe_pair_in),
	.byte_strobe_pair_out(byte_strobe_pair_out),
	.byte_strobe_pair_oe(byte_strobe_pair_oe));

// file: host_link.sv
// Purpose: host controller model driving the ddr link of the dram port
// Assumes: paced by clk falls; 16 clk per link half cycle
// Notes:   tasks are called from the bench; link clock still between frames
`timescale 1ns/100ps
module host_link #(
	parameter LAT = 6
) (
	input  wire         clk,         // pacing clock
	input  wire  [15:0] dq,          // resolved data wire
	input  wire  [1:0]  strobe,      // resolved strobe wire
	output logic        cs_n,        // chip select, active low
	output logic        link_ck,     // link clock
	output logic [15:0] host_dq,     // data driven by the host
	output logic        host_dq_oe,  // host drives the data wire
	output logic [1:0]  host_mask,   // write mask, 1 keeps the byte
	output logic        host_mask_oe // host drives the strobe wire
);
	logic [31:0] wd [0:15]; // write words
	logic [3:0]  wm [0:15]; // byte masks, bit b keeps byte b
	logic [31:0] rq [0:15]; // read words
	logic        flag;      // strobe seen in the command phase
	initial begin
		cs_n = 1'b1;
		link_ck = 1'b0;
		host_dq = 16'h0;
		host_dq_oe = 1'b0;
		host_mask = 2'b11;
		host_mask_oe = 1'b0;
		flag = 1'b0;
	end
	// one link half cycle, data set 5 clk before the edge and held 11 after
	task automatic half(input logic v, input logic [15:0] d,
		input logic [1:0] m);
		host_dq = d;
		host_mask = m;
		repeat (5) @(negedge clk);
		link_ck = v;
		repeat (11) @(negedge clk);
	endtask
	// one whole transaction of n double words
	task automatic xfer(input logic rd, input logic lin,
		input logic [31:0] a, input int n);
		logic [47:0] cmd_addr;
		int          i;
		int          lat;
		cmd_addr = {rd, 1'b0, lin, a[31:3], 13'h0, a[2:0]};
		host_dq_oe = 1'b1;
		cs_n = 1'b0; // link clock is low here
		repeat (8) @(negedge clk);
		for (i = 0; i < 6; i++) begin
			half(!i[0], {8'h00, cmd_addr[47 - 8 * i -: 8]}, 2'b11);
			if (i == 1)
				flag = strobe[0];
		end
		lat = flag ? 2 * LAT : LAT;
		host_dq_oe = !rd;
		host_mask_oe = !rd;
		for (i = 1; i < lat; i++) begin
			half(1'b1, 16'h0, 2'b11);
			half(1'b0, 16'h0, 2'b11);
		end
		// upper half on the rise, lower on the fall
		for (i = 0; i < n; i++) begin
			half(1'b1, wd[i][31:16], wm[i][3:2]);
			rq[i][31:16] = dq;
			half(1'b0, wd[i][15:0], wm[i][1:0]);
			rq[i][15:0] = dq;
		end
		cs_n = 1'b1; // short bursts leave room for refresh
		host_dq_oe = 1'b0;
		host_mask_oe = 1'b0;
		repeat (20) @(negedge clk);
	endtask
endmodule

// file: psram_ddr_x16_slave_port_test.sv
// Purpose: self-checking bench of the ddr dram slave port
// Assumes: 200 MHz clk; host model makes a 160 ns link clock
// Notes:   a mirror array predicts every read word
`timescale 1ns/100ps
`define CHK(g, e) begin \
	compares++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module psram_ddr_x16_slave_port_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        reset_n = 1'b1;
	logic [15:0] flt = 16'h0;
	logic [31:0] mem [0:255];
	integer      seed = 32'h762b;
	int          failures = 0;
	int          compares = 0;
	int          i;
	wire         cs_n, link_ck, host_dq_oe, host_mask_oe, dq_oe, bsp_oe;
	wire  [15:0] host_dq, dq_out, dq_w;
	wire  [1:0]  host_mask, bsp_out, bsp_w;
	always #2.5 clk = ~clk;
	// a released wire shows a pattern that changes every cycle
	always @(negedge clk) flt <= flt + 16'h3c5b;
	assign dq_w = dq_oe ? dq_out : (host_dq_oe ? host_dq : flt);
	assign bsp_w = bsp_oe ? bsp_out : (host_mask_oe ? host_mask : ~flt[1:0]);
	psram_ddr_port #(.REF_PERIOD(1000)) dut (
		.clk(clk), .rst(rst), .reset_n(reset_n), .cs_n(cs_n),
		.link_ck(link_ck), .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe),
		.byte_strobe_pair_in(bsp_w), .byte_strobe_pair_out(bsp_out),
		.byte_strobe_pair_oe(bsp_oe));
	host_link #(.LAT(6)) host (
		.clk(clk), .dq(dq_w), .strobe(bsp_w), .cs_n(cs_n),
		.link_ck(link_ck), .host_dq(host_dq), .host_dq_oe(host_dq_oe),
		.host_mask(host_mask), .host_mask_oe(host_mask_oe));
	// next double word of a burst
	function automatic logic [31:0] nxt(input logic [31:0] a, input logic lin);
		nxt = lin ? a + 32'h1 : {a[31:3], a[2:0] + 3'h1};
	endfunction
	// masked merge, mask bit b keeps byte b
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] w, input logic [3:0] m);
		int b;
		merge = w;
		for (b = 0; b < 4; b++)
			if (m[b])
				merge[8 * b +: 8] = o[8 * b +: 8];
	endfunction
	// plain write, masked write, then read back and compare
	task automatic run(input logic lin, input logic [31:0] a, input int n);
		logic [31:0] p;
		int          j;
		int          k;
		for (k = 0; k < 2; k++) begin
			p = a;
			for (j = 0; j < n; j++) begin
				host.wd[j] = $random(seed);
				host.wm[j] = k ? 4'($random(seed)) : 4'h0;
				mem[p[7:0]] = merge(mem[p[7:0]], host.wd[j], host.wm[j]);
				p = nxt(p, lin);
			end
			host.xfer(1'b0, lin, a, n);
		end
		host.xfer(1'b1, lin, a, n);
		p = a;
		for (j = 0; j < n; j++) begin
			`CHK(host.rq[j], mem[p[7:0]])
			p = nxt(p, lin);
		end
		$display("test done lin=%0d addr=%h words=%0d", lin, a, n);
	endtask
	task conclude;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		repeat (10) @(negedge clk);
		run(1'b0, 32'h0000_0107, 9); // wraps and passes the start word
		run(1'b1, 32'h0000_00fe, 5); // crosses groups linearly
		run(1'b0, 32'h0000_0040, 1);
		// reset pin low in mid-read releases the pins
		fork
			host.xfer(1'b1, 1'b1, 32'h0000_0010, 8);
			begin
				repeat (300) @(negedge clk);
				reset_n = 1'b0;
				repeat (10) @(negedge clk);
				`CHK(dq_oe, 1'b0)
				`CHK(bsp_oe, 1'b0)
			end
		join
		reset_n = 1'b1;
		repeat (10) @(negedge clk);
		$display("test done reset pin");
		for (i = 0; i < 6; i++)
			run(1'($random(seed)), $random(seed), 1 + int'($random(seed) & 11));
		conclude;
	end
	// watchdog against a hang
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		conclude;
	end
endmodule
